// file: tb/copper_packet_gen_checker_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module copper_packet_gen_checker_tb_top;
    logic pclk, presetn, psel, penable, pwrite, half_duplex, er;
    logic [7:0] paddr, b1, b2;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, rx_dv, rx_er, tx_en, tx_er, irq, stub_test_en;
    logic [7:0] rxd, txd;
    logic [10:0] coll, run = 0, idl = 0, len, gap;
    logic [15:0] w;
    int failures = 0, tests_run = 0, nfr = 0, ner = 0, f0, e0, g, nb, p;
    logic [7:0] ra[5] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h5c};
    logic [31:0] rv[5] = '{32'h0000_0000, 0, 0, 32'h0000_000c, 0};
    logic [10:0] lp[7] = '{64, 65, 96, 97, 128, 129, 70};
    logic [31:0] lx[7] = '{0, 1, 1, 32'h0000_0100, 32'h0000_0100, 0, 0};
    logic lh[7] = '{1, 1, 1, 1, 1, 1, 0};

    cpg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
        .half_duplex(half_duplex), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
        .irq(irq), .stub_test_en(stub_test_en));
    cpg_link_partner peer (.pclk(pclk), .presetn(presetn), .tx_en(tx_en),
        .tx_er(tx_er), .txd(txd), .coll_pos(coll), .rx_dv(rx_dv), .rx_er(rx_er),
        .rxd(rxd));

    // 25 MHz clock
    always #20 pclk = ~pclk;

    // Frame monitor: length, gap, first bytes, errored bytes
    always @(posedge pclk) begin
        if (tx_en) begin
            run <= run + 11'h001;
            ner <= ner + tx_er;
            idl <= 11'h000;
            if (run == 0) begin
                b1 <= txd;
                gap <= idl;
                nfr <= nfr + 1;
            end
            if (run == 1) b2 <= txd;
        end else begin
            idl <= idl + 11'h001;
            if (run != 0) len <= run;
            run <= 11'h000;
        end
    end

    task automatic end_sim;
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high, then idles
    // one cycle so a self-clearing write settles before the next setup samples
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Polls the done flag; a poll limit that runs out is a mismatch
    task automatic wdone;
        for (int k = 0; k < 3000; k++) begin
            apb(1'b0, 8'h40, 16'h0000);
            if (rd[7] === 1'b1) return;
        end
        failures++;
    endtask

    // Watchdog of 60000 cycles, well above the expected run of about 13000 cycles
    initial begin
        #2400000;
        failures++;
        end_sim;
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; half_duplex = 0; coll = 0;
        void'($urandom(32'h272e));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 16'h0000);
            chk("reset value", rv[i], rd);
        end
        apb(1'b0, 8'h00, 16'h0000);
        chk("unmapped pslverr", 1, er);
        apb(1'b1, 8'h48, 16'h0008);
        @(posedge pclk);
        chk("stub_test_en", 1, stub_test_en);
        apb(1'b1, 8'h7c, 16'h0001);
        // Random bursts on the loopback path
        for (int i = 0; i < 3; i++) begin
            g = $urandom % 16; nb = 2 + $urandom % 2; p = $urandom % 2;
            apb(1'b1, 8'h48, 16'h0010);
            apb(1'b0, 8'h44, 16'h0000);
            chk("counts cleared", 0, rd);
            apb(1'b0, 8'h48, 16'h0000);
            chk("reset bit", 0, rd);
            apb(1'b1, 8'h4c, 16'(g));
            f0 = nfr;
            w = 16'h0018 | (16'(nb) << 8) | (16'(p) << 2);
            apb(1'b1, 8'h40, w);
            wdone;
            chk("ctrl done", (w & 16'hfff7) | 16'h0080, rd);
            chk("frames", nb, nfr - f0);
            chk("length", 64, len);
            chk("gap", g + 1, gap);
            if (p) chk("pattern", 16'h5aa5, {b1, b2});
            apb(1'b0, 8'h44, 16'h0000);
            chk("rx counts", {nb[7:0], 8'h00}, rd);
            chk("irq", 1, irq);
            apb(1'b0, 8'h78, 16'h0000);
            chk("status", 1, rd);
            repeat (2) @(posedge pclk);
            chk("irq clear", 0, irq);
        end
        // Errored frames, enable held, trigger write refused then taken
        apb(1'b1, 8'h48, 16'h0010);
        f0 = nfr; e0 = ner;
        apb(1'b1, 8'h40, 16'h0259);
        wdone;
        chk("enable held", 16'h02d9, rd);
        apb(1'b1, 8'h40, 16'h02d9);
        repeat (20) @(posedge pclk);
        chk("one written", 2, nfr - f0);
        apb(1'b1, 8'h40, 16'h0259);
        wdone;
        chk("retrigger", 4, nfr - f0);
        chk("tx_er bytes", 4, ner - e0);
        apb(1'b0, 8'h44, 16'h0000);
        chk("bad counts", 16'h0404, rd);
        // Late collision windows, single long frames
        foreach (lp[i]) begin
            half_duplex <= lh[i];
            coll <= lp[i];
            apb(1'b1, 8'h40, 16'h010a);
            wdone;
            apb(1'b0, 8'h5c, 16'h0000);
            chk("late count", lx[i], rd);
        end
        // Continuous mode never reports done
        f0 = nfr;
        apb(1'b1, 8'h40, 16'h0008);
        repeat (800) @(posedge pclk);
        apb(1'b0, 8'h40, 16'h0000);
        chk("continuous", 16'h0008, rd);
        chk("cont frames", 1, (nfr - f0) > 5);
        apb(1'b1, 8'h40, 16'h0000);
        end_sim;
    end
endmodule
`default_nettype wire

// file: tb/cpg_link_partner.sv
`timescale 1ns/1ps
`default_nettype none

module cpg_link_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        tx_en,
    input  wire logic        tx_er,
    input  wire logic [7:0]  txd,
    input  wire logic [10:0] coll_pos,
    output logic             rx_dv,
    output logic             rx_er,
    output logic      [7:0]  rxd
);
    logic [10:0] pos_q;

    // Zero coll_pos echoes the frame; else a one-byte start lands on that tx byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 11'h000;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd   <= 8'h00;
        end else begin
            pos_q <= tx_en ? pos_q + 11'h001 : 11'h000;
            if (coll_pos == 11'h000) begin
                rx_dv <= tx_en;
                rx_er <= tx_er;
                rxd   <= tx_en ? txd : ~rxd; // Idle line must not hold a stale byte
            end else begin
                rx_dv <= tx_en && (pos_q + 11'h002 == coll_pos);
                rx_er <= 1'b0;
                rxd   <= ~rxd;
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/cpg_crc32.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpg_params.svh"

module cpg_crc32 import cpg_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [31:0] crc_q
);

    // Reflected byte-wise update, LSB of the byte first as on the wire
    function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CPG_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Clear together with a byte folds that byte into a fresh CRC
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= `CPG_CRC_INIT;
        end else if (en) begin
            crc_q <= crc_next(clr ? `CPG_CRC_INIT : crc_q, data);
        end else if (clr) begin
            crc_q <= `CPG_CRC_INIT;
        end
    end

endmodule
`default_nettype wire

// file: verilog/cpg_params.svh
`ifndef CPG_PARAMS_SVH
`define CPG_PARAMS_SVH

// Register indices; byte address is four times the index
`define CPG_IDX_GEN_CTRL   6'h10
`define CPG_IDX_CHK_COUNT  6'h11
`define CPG_IDX_CHK_CTRL   6'h12
`define CPG_IDX_GAP_LEN    6'h13
`define CPG_IDX_LATE_COLL  6'h17
`define CPG_IDX_IRQ_STATUS 6'h1E
`define CPG_IDX_IRQ_MASK   6'h1F

// Generator control field positions
`define CPG_GEN_BURST_LSB  8
`define CPG_GEN_TRIG       7
`define CPG_GEN_SELFCLR    6
`define CPG_GEN_RSVD       5
`define CPG_GEN_CRC_EN     4
`define CPG_GEN_ENABLE     3
`define CPG_GEN_PATTERN    2
`define CPG_GEN_LONG       1
`define CPG_GEN_ERRORED    0

// Checker control field positions
`define CPG_CHK_CNT_RST    4
`define CPG_CHK_STUB       3

// Interrupt status bit positions
`define CPG_IRQ_DONE       0
`define CPG_IRQ_CRC_ERR    1
`define CPG_IRQ_LATE_COLL  2

// Reset values
`define CPG_GEN_CTRL_RST   16'h0000
`define CPG_GAP_LEN_RST    8'h0c
`define CPG_LFSR_SEED      16'hace1

// Frame geometry in bytes
`define CPG_FRAME_LONG     11'h5ee
`define CPG_FRAME_SHORT    11'h040
`define CPG_FCS_BYTES      11'h004
`define CPG_LC_A_FIRST     11'h041
`define CPG_LC_A_LAST      11'h060
`define CPG_LC_B_FIRST     11'h061
`define CPG_LC_B_LAST      11'h080

// Frame check sequence constants
`define CPG_CRC_POLY       32'hedb8_8320
`define CPG_CRC_INIT       32'hffff_ffff
`define CPG_CRC_RESIDUE    32'hdebb_20e3

`endif

// file: verilog/cpg_pkg.sv
package cpg_pkg;

    // Transmit sequencer states
    typedef enum logic [1:0] {
        CPG_TX_IDLE,
        CPG_TX_DATA,
        CPG_TX_GAP
    } cpg_tx_state_e;

    typedef logic [15:0] cpg_word_t;

endpackage

// file: verilog/cpg_top.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpg_params.svh"

module cpg_top import cpg_pkg::*; #(
    parameter int unsigned AW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          rx_dv,
    input  wire logic          rx_er,
    input  wire logic [7:0]    rxd,
    input  wire logic          half_duplex,
    output logic               tx_en,
    output logic               tx_er,
    output logic      [7:0]    txd,
    output logic               irq,
    output logic               stub_test_en
);

    // Generator control fields
    logic [7:0]  burst_q;
    logic        done_q, selfclr_q, rsvd_q, crc_en_q, gen_en_q;
    logic        pattern_q, long_q, errored_q;
    logic [7:0]  sent_q;
    logic [2:0]  chk_rsvd_q;
    logic [7:0]  gap_rsvd_q, ipg_q;
    logic        cnt_rst_q;
    // Transmit path
    cpg_tx_state_e state_q;
    logic [10:0] pos_q;
    logic [7:0]  gap_cnt_q;
    logic [15:0] lfsr_q;
    logic [31:0] tx_crc;
    // Receive checker
    logic        rx_prev_q, rx_bad_q;
    logic [31:0] rx_crc;
    logic [7:0]  pkt_cnt_q, err_cnt_q;
    logic [7:0]  lc_a_q, lc_b_q;
    // Interrupts
    logic [2:0]  irq_st_q, irq_mask_q;
    logic [8:0]  idle_cnt_q;

    // Bus phases; the slave is always ready, so an access is one cycle
    logic        setup, wr_acc, rd_acc;
    logic [5:0]  idx;
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign idx    = paddr[7:2];

    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic inc);
        return (inc && v != 8'hff) ? v + 8'h01 : v;
    endfunction

    function automatic logic mapped(input logic [5:0] i, input logic [1:0] lo);
        return lo == 2'h0 && (i == `CPG_IDX_GEN_CTRL || i == `CPG_IDX_CHK_COUNT
            || i == `CPG_IDX_CHK_CTRL || i == `CPG_IDX_GAP_LEN || i == `CPG_IDX_LATE_COLL
            || i == `CPG_IDX_IRQ_STATUS || i == `CPG_IDX_IRQ_MASK);
    endfunction

    function automatic cpg_word_t rd_mux(input logic [5:0] i);
        case (i)
            `CPG_IDX_GEN_CTRL:   rd_mux = {burst_q, done_q, selfclr_q, rsvd_q, crc_en_q,
                                           gen_en_q, pattern_q, long_q, errored_q};
            `CPG_IDX_CHK_COUNT:  rd_mux = {pkt_cnt_q, err_cnt_q};
            `CPG_IDX_CHK_CTRL:   rd_mux = {11'h000, 1'b0, stub_test_en, chk_rsvd_q};
            `CPG_IDX_GAP_LEN:    rd_mux = {gap_rsvd_q, ipg_q};
            `CPG_IDX_LATE_COLL:  rd_mux = {lc_b_q, lc_a_q};
            `CPG_IDX_IRQ_STATUS: rd_mux = {13'h0000, irq_st_q};
            `CPG_IDX_IRQ_MASK:   rd_mux = {13'h0000, irq_mask_q};
            default:             rd_mux = 16'h0000;
        endcase
    endfunction

    logic wr_gen, wr_chk, wr_gap, wr_mask, rd_lc, rd_st;
    assign wr_gen  = wr_acc && mapped(idx, paddr[1:0]) && idx == `CPG_IDX_GEN_CTRL;
    assign wr_chk  = wr_acc && mapped(idx, paddr[1:0]) && idx == `CPG_IDX_CHK_CTRL;
    assign wr_gap  = wr_acc && mapped(idx, paddr[1:0]) && idx == `CPG_IDX_GAP_LEN;
    assign wr_mask = wr_acc && mapped(idx, paddr[1:0]) && idx == `CPG_IDX_IRQ_MASK;
    assign rd_lc   = rd_acc && mapped(idx, paddr[1:0]) && idx == `CPG_IDX_LATE_COLL;
    assign rd_st   = rd_acc && mapped(idx, paddr[1:0]) && idx == `CPG_IDX_IRQ_STATUS;

    // Read data is snapshotted in the setup cycle; read-clears later subtract the snapshot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= {16'h0000, mapped(idx, paddr[1:0]) ? rd_mux(idx) : 16'h0000};
                pslverr <= !mapped(idx, paddr[1:0]);
            end
        end
    end

    // Frame boundaries seen by the control logic
    logic frame_end, last_frame, trig_valid, start;
    assign frame_end  = state_q == CPG_TX_GAP && gap_cnt_q == ipg_q;
    assign last_frame = burst_q != 8'h00 && sent_q + 8'h01 == burst_q;
    assign trig_valid = selfclr_q && gen_en_q && burst_q != 8'h00;
    assign start      = gen_en_q && !done_q
                        && (state_q == CPG_TX_IDLE || (frame_end && !last_frame));

    // Generator control; a burst finishing in the same cycle as a write still marks done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {burst_q, done_q, selfclr_q, rsvd_q, crc_en_q} <= 12'(`CPG_GEN_CTRL_RST >> 4);
            {gen_en_q, pattern_q, long_q, errored_q}        <= 4'(`CPG_GEN_CTRL_RST);
            sent_q <= 8'h00;
        end else begin
            if (wr_gen) begin
                burst_q   <= pwdata[`CPG_GEN_BURST_LSB +: 8];
                selfclr_q <= pwdata[`CPG_GEN_SELFCLR];
                rsvd_q    <= pwdata[`CPG_GEN_RSVD];
                crc_en_q  <= pwdata[`CPG_GEN_CRC_EN];
                gen_en_q  <= pwdata[`CPG_GEN_ENABLE];
                pattern_q <= pwdata[`CPG_GEN_PATTERN];
                long_q    <= pwdata[`CPG_GEN_LONG];
                errored_q <= pwdata[`CPG_GEN_ERRORED];
                // Fresh enable or a zero written over a done trigger re-arms the burst
                if ((!gen_en_q && pwdata[`CPG_GEN_ENABLE])
                    || (trig_valid && done_q && !pwdata[`CPG_GEN_TRIG])) begin
                    done_q <= 1'b0;
                    sent_q <= 8'h00;
                end
            end
            if (frame_end && burst_q != 8'h00) begin
                if (last_frame) begin
                    done_q <= 1'b1;
                    sent_q <= 8'h00;
                    if (!selfclr_q) begin
                        gen_en_q <= 1'b0;
                    end
                end else begin
                    sent_q <= sent_q + 8'h01;
                end
            end
        end
    end

    // Checker control and gap setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_rst_q    <= 1'b0;
            stub_test_en <= 1'b0;
            chk_rsvd_q   <= 3'h0;
            gap_rsvd_q   <= 8'h00;
            ipg_q        <= `CPG_GAP_LEN_RST;
        end else begin
            cnt_rst_q <= wr_chk && pwdata[`CPG_CHK_CNT_RST];
            if (wr_chk) begin
                stub_test_en <= pwdata[`CPG_CHK_STUB];
                chk_rsvd_q   <= pwdata[2:0];
            end
            if (wr_gap) begin
                gap_rsvd_q <= pwdata[15:8];
                ipg_q      <= pwdata[7:0];
            end
        end
    end

    // Payload byte for a 1-based frame position
    logic [10:0] flen, nxt_pos;
    logic        nxt_fcs;
    logic [1:0]  fcs_idx;
    logic [7:0]  pay_byte, fcs_byte;
    assign flen     = long_q ? `CPG_FRAME_LONG : `CPG_FRAME_SHORT;
    assign nxt_pos  = (state_q == CPG_TX_DATA) ? pos_q + 11'h001 : 11'h001;
    assign nxt_fcs  = nxt_pos > flen - `CPG_FCS_BYTES;
    assign fcs_idx  = 2'(nxt_pos - (flen - `CPG_FCS_BYTES) - 11'h001);
    assign pay_byte = pattern_q ? (nxt_pos[0] ? 8'h5a : 8'ha5) : lfsr_q[7:0];
    // Errored frames send the uncomplemented CRC so the check fails
    assign fcs_byte = errored_q ? tx_crc[8*fcs_idx +: 8] : ~tx_crc[8*fcs_idx +: 8];

    cpg_crc32 u_tx_crc (
        .clk   (pclk),
        .rst_n (presetn),
        .clr   (start),
        .en    ((start || state_q == CPG_TX_DATA) && !nxt_fcs && nxt_pos <= flen),
        .data  (pay_byte),
        .crc_q (tx_crc)
    );

    // Transmit sequencer; a disable only takes effect between frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= CPG_TX_IDLE;
            pos_q     <= 11'h000;
            gap_cnt_q <= 8'h00;
            lfsr_q    <= `CPG_LFSR_SEED;
            tx_en     <= 1'b0;
            tx_er     <= 1'b0;
            txd       <= 8'h00;
        end else begin
            case (state_q)
                CPG_TX_IDLE, CPG_TX_GAP: begin
                    gap_cnt_q <= gap_cnt_q + 8'h01;
                    if (start) begin
                        state_q <= CPG_TX_DATA;
                        pos_q   <= 11'h001;
                        tx_en   <= 1'b1;
                        txd     <= pay_byte;
                        lfsr_q  <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
                    end else if (frame_end) begin
                        state_q <= CPG_TX_IDLE;
                    end
                end
                CPG_TX_DATA: begin
                    if (pos_q == flen) begin
                        state_q   <= CPG_TX_GAP;
                        gap_cnt_q <= 8'h00;
                        tx_en     <= 1'b0;
                        tx_er     <= 1'b0;
                        txd       <= 8'h00;
                    end else begin
                        pos_q <= nxt_pos;
                        txd   <= nxt_fcs ? fcs_byte : pay_byte;
                        // Symbol error rides on the last check byte of an errored frame
                        tx_er <= errored_q && nxt_pos == flen;
                        if (!nxt_fcs) begin
                            lfsr_q <= {lfsr_q[14:0],
                                       lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
                        end
                    end
                end
                default: begin
                    state_q <= CPG_TX_IDLE;
                    tx_en   <= 1'b0;
                end
            endcase
        end
    end

    // Receive checker: residue test over data and check bytes
    logic rx_start, rx_end, rx_count, rx_bad;
    assign rx_start = rx_dv && !rx_prev_q;
    assign rx_end   = !rx_dv && rx_prev_q;
    assign rx_count = rx_end && crc_en_q;
    assign rx_bad   = rx_count && (rx_bad_q || rx_crc != `CPG_CRC_RESIDUE);

    cpg_crc32 u_rx_crc (
        .clk   (pclk),
        .rst_n (presetn),
        .clr   (rx_start),
        .en    (rx_dv),
        .data  (rxd),
        .crc_q (rx_crc)
    );

    // Counters hold their value while the checker is disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_q <= 1'b0;
            rx_bad_q  <= 1'b0;
            pkt_cnt_q <= 8'h00;
            err_cnt_q <= 8'h00;
        end else begin
            rx_prev_q <= rx_dv;
            rx_bad_q  <= rx_start ? rx_er : (rx_bad_q || (rx_dv && rx_er));
            if (cnt_rst_q) begin
                pkt_cnt_q <= 8'h00;
                err_cnt_q <= 8'h00;
            end else begin
                pkt_cnt_q <= sat_inc(pkt_cnt_q, rx_count);
                err_cnt_q <= sat_inc(err_cnt_q, rx_bad);
            end
        end
    end

    // Late collisions judged by the position of the byte now on the transmit bus
    logic lc_a_hit, lc_b_hit;
    assign lc_a_hit = half_duplex && rx_start && tx_en
                      && pos_q >= `CPG_LC_A_FIRST && pos_q <= `CPG_LC_A_LAST;
    assign lc_b_hit = half_duplex && rx_start && tx_en
                      && pos_q >= `CPG_LC_B_FIRST && pos_q <= `CPG_LC_B_LAST;

    // Clear-on-read subtracts what was read, so a hit during the read is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_a_q <= 8'h00;
            lc_b_q <= 8'h00;
        end else if (rd_lc) begin
            lc_a_q <= sat_inc(lc_a_q - prdata[7:0], lc_a_hit);
            lc_b_q <= sat_inc(lc_b_q - prdata[15:8], lc_b_hit);
        end else begin
            lc_a_q <= sat_inc(lc_a_q, lc_a_hit);
            lc_b_q <= sat_inc(lc_b_q, lc_b_hit);
        end
    end

    // Sticky events, read-clear with set winning, masked onto one level output
    logic [2:0] ev, st_d;
    assign ev = {lc_a_hit || lc_b_hit, rx_bad, frame_end && last_frame};
    assign st_d = (rd_st ? (irq_st_q & ~prdata[2:0]) : irq_st_q) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q   <= 3'h0;
            irq_mask_q <= 3'h0;
            irq        <= 1'b0;
        end else begin
            irq_st_q <= st_d;
            if (wr_mask) begin
                irq_mask_q <= pwdata[2:0];
            end
            irq <= |(st_d & (wr_mask ? pwdata[2:0] : irq_mask_q));
        end
    end

    // Helper for checks: idle cycles since the transmit bus last dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_q <= 9'h1ff;
        end else if (tx_en) begin
            idle_cnt_q <= 9'h000;
        end else if (idle_cnt_q != 9'h1ff) begin
            idle_cnt_q <= idle_cnt_q + 9'h001;
        end
    end

    AST_DONE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        done_q |-> !tx_en)
        else $error("transmit active while burst done");
    AST_SELFCLR_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_q) && !$past(selfclr_q) && !$past(wr_gen) |-> !gen_en_q)
        else $error("enable did not self clear");
    AST_SELFCLR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_q) && $past(selfclr_q) && !$past(wr_gen) |-> gen_en_q)
        else $error("enable cleared with self clear control set");
    AST_CONTINUOUS: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_q) |-> $past(burst_q) != 8'h00)
        else $error("continuous mode ended");
    AST_FRAME_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(tx_en) && $stable(long_q) |-> $past(pos_q) == flen)
        else $error("frame length wrong");
    AST_SYMBOL_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        tx_er |-> tx_en && errored_q && pos_q == flen)
        else $error("symbol error outside errored frame end");
    AST_GAP_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_en) && $stable(ipg_q) |-> idle_cnt_q >= {1'b0, ipg_q} + 9'h001)
        else $error("inter packet gap too short");
    AST_PKT_SAT: assert property (@(posedge pclk) disable iff (!presetn)
        pkt_cnt_q == 8'hff && !cnt_rst_q |=> pkt_cnt_q == 8'hff)
        else $error("packet counter wrapped");
    AST_ERR_SAT: assert property (@(posedge pclk) disable iff (!presetn)
        err_cnt_q == 8'hff && !cnt_rst_q |=> err_cnt_q == 8'hff)
        else $error("crc error counter wrapped");
    AST_CNT_RST: assert property (@(posedge pclk) disable iff (!presetn)
        wr_chk && pwdata[`CPG_CHK_CNT_RST] |=> cnt_rst_q ##1 (pkt_cnt_q == 8'h00
            && err_cnt_q == 8'h00 && !cnt_rst_q))
        else $error("counter reset failed");
    AST_CHK_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        !crc_en_q && !cnt_rst_q |=> $stable(pkt_cnt_q))
        else $error("checker counted while disabled");
    AST_LC_FULL: assert property (@(posedge pclk) disable iff (!presetn)
        lc_a_q > $past(lc_a_q) |-> $past(half_duplex))
        else $error("late collision counted in full duplex");
    AST_LC_SAT: assert property (@(posedge pclk) disable iff (!presetn)
        lc_b_q == 8'hff && !rd_lc |=> lc_b_q == 8'hff)
        else $error("late collision counter wrapped");

endmodule
`default_nettype wire
